// ===== code_protection_pkg.sv
// shared constants for the code protection checker
package code_protection_pkg;
  localparam int ADDR_W = 22;
  // protection configuration byte addresses
  localparam logic [21:0] CODE_PROTECT_BLOCKS_ADDR = 22'h300008;
  localparam logic [21:0] CODE_PROTECT_BOOT_DATA_ADDR = 22'h300009;
  localparam logic [21:0] WRITE_PROTECT_BLOCKS_ADDR = 22'h30000a;
  localparam logic [21:0] WRITE_PROTECT_BOOT_DATA_CFG_ADDR = 22'h30000b;
  localparam logic [21:0] TABLE_READ_PROTECT_BLOCKS_ADDR = 22'h30000c;
  localparam logic [21:0] TABLE_READ_PROTECT_BOOT_ADDR = 22'h30000d;
  // configuration space window
  localparam logic [21:0] CONFIG_BASE_ADDR = 22'h300000;
  localparam logic [21:0] CONFIG_LAST_ADDR = 22'h3fffff;
  // user identification locations
  localparam logic [21:0] ID_FIRST_ADDR = 22'h200000;
  localparam logic [21:0] ID_LAST_ADDR = 22'h200007;
  // field positions
  localparam int BOOT_BIT = 6;
  localparam int DATA_BIT = 7;
  localparam int CFG_BIT = 5;
  localparam int REGION_BITS = 4;
  // boot block sizes in bytes
  localparam logic [21:0] BOOT_SMALL_BYTES = 22'h000200;
  localparam logic [21:0] BOOT_LARGE_BYTES = 22'h000800;
  // memory sizes in bytes
  localparam logic [21:0] MEM_8K = 22'h002000;
  localparam logic [21:0] MEM_16K = 22'h004000;
  localparam logic [21:0] MEM_32K = 22'h008000;
  localparam logic [21:0] MEM_64K = 22'h010000;
  // unprogrammed protection byte masks
  localparam logic [7:0] BLOCKS_MASK_FULL = 8'h0f;
  localparam logic [7:0] BLOCKS_MASK_SMALL = 8'h03;
  localparam logic [7:0] BOOT_DATA_MASK = 8'hc0;
  localparam logic [7:0] WRITE_BOOT_DATA_CFG_MASK = 8'he0;
  localparam logic [7:0] READ_BOOT_MASK = 8'h40;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // region codes
  typedef enum logic [2:0]
  {
    REGION_0 = 3'b000,
    REGION_1 = 3'b001,
    REGION_2 = 3'b010,
    REGION_3 = 3'b011,
    REGION_BOOT = 3'b100,
    REGION_NONE = 3'b111
  } region_t;
endpackage

// ===== region_decoder.sv
// maps a program address onto its protection region
`timescale 1ns/1ps
module region_decoder
  import code_protection_pkg::*;
#(
  parameter logic [21:0] MEM_BYTES = MEM_64K
)
(
  // address in
  input wire logic [21:0] addr,
  // region out
  output region_t region
);
  localparam logic [21:0] BOOT_BYTES = (MEM_BYTES == MEM_8K) ? BOOT_SMALL_BYTES : BOOT_LARGE_BYTES;
  localparam logic [21:0] QUARTER = MEM_BYTES >> 2;
  localparam logic [21:0] HALF = MEM_BYTES >> 1;
  localparam bool_four = (MEM_BYTES >= MEM_32K);

  // binary-boundary split: small parts use two halves, large parts four quarters
  always_comb
  begin
    if (addr >= MEM_BYTES)
      region = REGION_NONE;
    else if (addr < BOOT_BYTES)
      region = REGION_BOOT;
    else if (bool_four)
    begin
      if (addr < QUARTER)
        region = REGION_0;
      else if (addr < HALF)
        region = REGION_1;
      else if (addr < HALF + QUARTER)
        region = REGION_2;
      else
        region = REGION_3;
    end
    else if (addr < HALF)
      region = REGION_0;
    else
      region = REGION_1;
  end
endmodule

// ===== code_protection_checker.sv
// access permission checker for program, data memory and configuration
`timescale 1ns/1ps
module code_protection_checker
  import code_protection_pkg::*;
#(
  parameter logic [21:0] MEM_BYTES = MEM_64K
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // program memory access request
  input wire logic accessValid,
  input wire logic accessWrite,
  input wire logic accessExternal,
  input wire logic [21:0] tablePointer,
  input wire logic [21:0] programCounter,
  input wire logic [7:0] writeData,
  input wire logic [7:0] memReadData,
  // data memory access request
  input wire logic dataValid,
  input wire logic dataWrite,
  input wire logic dataExternal,
  // programmer erase strobes
  input wire logic chipErase,
  input wire logic blockErase,
  input wire logic [2:0] eraseRegion,
  // program memory answer
  output logic accessDone,
  output logic accessGranted,
  output logic [7:0] readData,
  output logic memWriteEnable,
  // data memory answer
  output logic dataGranted,
  // configuration bits out
  output logic configWriteProtect
);
  localparam bool_four = (MEM_BYTES >= MEM_32K);
  localparam logic [7:0] BLOCKS_MASK = bool_four ? BLOCKS_MASK_FULL : BLOCKS_MASK_SMALL;

  logic [7:0] codeProtectBlocks_ff;
  logic [7:0] codeProtectBootData_ff;
  logic [7:0] writeProtectBlocks_ff;
  logic [7:0] writeProtectBootDataCfg_ff;
  logic [7:0] tableReadProtectBlocks_ff;
  logic [7:0] tableReadProtectBoot_ff;
  logic accessDone_ff;
  logic accessGranted_ff;
  logic [7:0] readData_ff;
  logic memWriteEnable_ff;
  logic dataGranted_ff;
  region_t sourceRegion;
  region_t targetRegion;
  logic inConfig;
  logic inId;
  logic isProtReg;
  logic codeProtect;
  logic writeProtect;
  logic readProtect;
  logic allowed;
  logic [7:0] configByte;
  logic [7:0] nxt_readData;
  logic [7:0] eraseMask;
  // erase pins after the two-flop synchronisers
  logic chipEraseMeta_ff;
  logic chipEraseSync_ff;
  logic blockEraseMeta_ff;
  logic blockEraseSync_ff;
  logic [2:0] eraseRegionMeta_ff;
  logic [2:0] eraseRegionSync_ff;

  // two decoders: one for the instruction location, one for the target
  region_decoder #(.MEM_BYTES(MEM_BYTES)) sourceDecoder
  (
    .addr(programCounter),
    .region(sourceRegion)
  );
  region_decoder #(.MEM_BYTES(MEM_BYTES)) targetDecoder
  (
    .addr(tablePointer),
    .region(targetRegion)
  );

  // address class of the pointer
  assign inConfig = (tablePointer >= CONFIG_BASE_ADDR) && (tablePointer <= CONFIG_LAST_ADDR);
  assign inId = (tablePointer >= ID_FIRST_ADDR) && (tablePointer <= ID_LAST_ADDR);
  assign isProtReg = (tablePointer >= CODE_PROTECT_BLOCKS_ADDR) &&
                     (tablePointer <= TABLE_READ_PROTECT_BOOT_ADDR);

  // protection bits of the target region
  always_comb
  begin
    codeProtect = 1'b0;
    writeProtect = 1'b0;
    readProtect = 1'b0;
    case (targetRegion)
      REGION_0, REGION_1, REGION_2, REGION_3:
      begin
        codeProtect = !codeProtectBlocks_ff[targetRegion[1:0]];
        writeProtect = !writeProtectBlocks_ff[targetRegion[1:0]];
        readProtect = !tableReadProtectBlocks_ff[targetRegion[1:0]];
      end
      REGION_BOOT:
      begin
        codeProtect = !codeProtectBootData_ff[BOOT_BIT];
        writeProtect = !writeProtectBootDataCfg_ff[BOOT_BIT];
        readProtect = !tableReadProtectBoot_ff[BOOT_BIT];
      end
      default:
      begin
        codeProtect = 1'b0;
        writeProtect = 1'b0;
        readProtect = 1'b0;
      end
    endcase
  end

  // current value of an addressed protection byte, unimplemented bits zero
  always_comb
  begin
    case (tablePointer)
      CODE_PROTECT_BLOCKS_ADDR: configByte = codeProtectBlocks_ff;
      CODE_PROTECT_BOOT_DATA_ADDR: configByte = codeProtectBootData_ff;
      WRITE_PROTECT_BLOCKS_ADDR: configByte = writeProtectBlocks_ff;
      WRITE_PROTECT_BOOT_DATA_CFG_ADDR: configByte = writeProtectBootDataCfg_ff;
      TABLE_READ_PROTECT_BLOCKS_ADDR: configByte = tableReadProtectBlocks_ff;
      TABLE_READ_PROTECT_BOOT_ADDR: configByte = tableReadProtectBoot_ff;
      default: configByte = BYTE_ZERO;
    endcase
  end

  // permission decision for one program-space access
  always_comb
  begin
    allowed = 1'b1;
    if (inId)
      allowed = 1'b1;
    else if (inConfig)
    begin
      // configuration is locked against writes once the cfg bit is cleared; only the programmer may touch the lock itself
      if (accessWrite && !configWriteProtect)
        allowed = 1'b0;
      else if (accessWrite && !accessExternal && tablePointer == WRITE_PROTECT_BOOT_DATA_CFG_ADDR)
        allowed = 1'b0;
    end
    else if (targetRegion == REGION_NONE)
      allowed = !accessWrite;
    else if (accessExternal && codeProtect)
      allowed = 1'b0;
    else if (accessWrite && writeProtect)
      allowed = 1'b0;
    else if (!accessWrite && !accessExternal && readProtect && sourceRegion != targetRegion)
      allowed = 1'b0;
    else
      allowed = 1'b1;
  end

  // read data: refused or unimplemented gives zeros
  always_comb
  begin
    nxt_readData = BYTE_ZERO;
    if (allowed && !accessWrite)
    begin
      if (isProtReg)
        nxt_readData = configByte;
      else if (inConfig || inId || targetRegion != REGION_NONE)
        nxt_readData = memReadData;
      else
        nxt_readData = BYTE_ZERO;
    end
  end

  // erase restores bits to one; whole chip or one region
  always_comb
  begin
    eraseMask = BYTE_ZERO;
    if (blockEraseSync_ff && eraseRegionSync_ff != REGION_BOOT && eraseRegionSync_ff[2] == 1'b0)
      eraseMask = BLOCKS_MASK & (8'h01 << eraseRegionSync_ff[1:0]);
  end

  // erase pins are asynchronous to clk; two flops each before any logic reads them
  // the region code rides the same stages, so the programmer must hold it around the strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      chipEraseMeta_ff <= 1'b0;
      chipEraseSync_ff <= 1'b0;
      blockEraseMeta_ff <= 1'b0;
      blockEraseSync_ff <= 1'b0;
      eraseRegionMeta_ff <= 3'h0;
      eraseRegionSync_ff <= 3'h0;
    end
    else
    begin
      chipEraseMeta_ff <= chipErase;
      chipEraseSync_ff <= chipEraseMeta_ff;
      blockEraseMeta_ff <= blockErase;
      blockEraseSync_ff <= blockEraseMeta_ff;
      eraseRegionMeta_ff <= eraseRegion;
      eraseRegionSync_ff <= eraseRegionMeta_ff;
    end
  end

  // program access answer registered one cycle after the request
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      accessDone_ff <= 1'b0;
      accessGranted_ff <= 1'b0;
      readData_ff <= BYTE_ZERO;
      memWriteEnable_ff <= 1'b0;
    end
    else
    begin
      accessDone_ff <= accessValid;
      accessGranted_ff <= accessValid && allowed;
      readData_ff <= accessValid ? nxt_readData : BYTE_ZERO;
      // protection bytes are not memory; they update locally
      memWriteEnable_ff <= accessValid && accessWrite && allowed && !isProtReg;
    end
  end

  // data memory answer
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      dataGranted_ff <= 1'b0;
    else if (!dataValid)
      dataGranted_ff <= 1'b0;
    else if (dataWrite && !writeProtectBootDataCfg_ff[DATA_BIT])
      dataGranted_ff <= 1'b0;
    else if (dataExternal && !codeProtectBootData_ff[DATA_BIT])
      dataGranted_ff <= 1'b0;
    else
      dataGranted_ff <= 1'b1;
  end

  // protection bytes: reset shows the erased state, writes can only clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      codeProtectBlocks_ff <= BLOCKS_MASK;
      codeProtectBootData_ff <= BOOT_DATA_MASK;
      writeProtectBlocks_ff <= BLOCKS_MASK;
      writeProtectBootDataCfg_ff <= WRITE_BOOT_DATA_CFG_MASK;
      tableReadProtectBlocks_ff <= BLOCKS_MASK;
      tableReadProtectBoot_ff <= READ_BOOT_MASK;
    end
    else if (chipEraseSync_ff)
    begin
      codeProtectBlocks_ff <= BLOCKS_MASK;
      codeProtectBootData_ff <= BOOT_DATA_MASK;
      writeProtectBlocks_ff <= BLOCKS_MASK;
      writeProtectBootDataCfg_ff <= WRITE_BOOT_DATA_CFG_MASK;
      tableReadProtectBlocks_ff <= BLOCKS_MASK;
      tableReadProtectBoot_ff <= READ_BOOT_MASK;
    end
    else if (blockEraseSync_ff)
    begin
      codeProtectBlocks_ff <= codeProtectBlocks_ff | eraseMask;
      writeProtectBlocks_ff <= writeProtectBlocks_ff | eraseMask;
      tableReadProtectBlocks_ff <= tableReadProtectBlocks_ff | eraseMask;
      if (eraseRegionSync_ff == REGION_BOOT)
      begin
        codeProtectBootData_ff[BOOT_BIT] <= 1'b1;
        writeProtectBootDataCfg_ff[BOOT_BIT] <= 1'b1;
        tableReadProtectBoot_ff[BOOT_BIT] <= 1'b1;
      end
    end
    else if (accessValid && accessWrite && allowed && isProtReg)
    begin
      // and-ing keeps a zero bit zero whatever is written
      case (tablePointer)
        CODE_PROTECT_BLOCKS_ADDR: codeProtectBlocks_ff <= codeProtectBlocks_ff & writeData;
        CODE_PROTECT_BOOT_DATA_ADDR: codeProtectBootData_ff <= codeProtectBootData_ff & writeData;
        WRITE_PROTECT_BLOCKS_ADDR: writeProtectBlocks_ff <= writeProtectBlocks_ff & writeData;
        WRITE_PROTECT_BOOT_DATA_CFG_ADDR: writeProtectBootDataCfg_ff <= writeProtectBootDataCfg_ff & writeData;
        TABLE_READ_PROTECT_BLOCKS_ADDR: tableReadProtectBlocks_ff <= tableReadProtectBlocks_ff & writeData;
        TABLE_READ_PROTECT_BOOT_ADDR: tableReadProtectBoot_ff <= tableReadProtectBoot_ff & writeData;
        default: codeProtectBlocks_ff <= codeProtectBlocks_ff;
      endcase
    end
  end

  // outputs
  assign configWriteProtect = writeProtectBootDataCfg_ff[CFG_BIT];
  assign accessDone = accessDone_ff;
  assign accessGranted = accessGranted_ff;
  assign readData = readData_ff;
  assign memWriteEnable = memWriteEnable_ff;
  assign dataGranted = dataGranted_ff;
endmodule

// ===== code_protection_checker_props.sv
// assertions on the code protection checker ports
`timescale 1ns/1ps
module code_protection_checker_props
  import code_protection_pkg::*;
#(
  parameter logic [21:0] MEM_BYTES = MEM_64K
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // requests
  input wire logic accessValid,
  input wire logic accessWrite,
  input wire logic accessExternal,
  input wire logic [21:0] tablePointer,
  input wire logic [21:0] programCounter,
  input wire logic [7:0] memReadData,
  input wire logic dataValid,
  input wire logic dataWrite,
  input wire logic dataExternal,
  input wire logic chipErase,
  input wire logic blockErase,
  // answers
  input wire logic accessDone,
  input wire logic accessGranted,
  input wire logic [7:0] readData,
  input wire logic memWriteEnable,
  input wire logic dataGranted,
  input wire logic configWriteProtect
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_done_one_cycle: assert property (accessValid |=> accessDone) else $error("no answer");
  a_done_one_pulse: assert property (!accessValid |=> !accessDone) else $error("stray answer");
  a_refused_zero_data: assert property (accessDone && !accessGranted |-> readData == 8'h00) else $error("data leak");
  a_write_needs_grant: assert property (memWriteEnable |-> accessGranted && $past(accessWrite)) else $error("bad we");
  a_id_always_read: assert property (accessValid && !accessWrite && tablePointer >= ID_FIRST_ADDR
    && tablePointer <= ID_LAST_ADDR |=> accessGranted) else $error("id refused");
  a_cfg_write_block: assert property (accessValid && accessWrite && tablePointer >= CONFIG_BASE_ADDR
    && !configWriteProtect |=> !accessGranted) else $error("cfg written");
  a_cfg_set_erase: assert property ($rose(configWriteProtect) |-> $past(chipErase, 3) || $past(blockErase, 3))
    else $error("cfg bit set");
  a_cpu_data_read: assert property (dataValid && !dataWrite && !dataExternal |=> dataGranted)
    else $error("data read refused");
  a_same_region_read: assert property (accessValid && !accessWrite && !accessExternal && tablePointer[21:14] == 8'h01
    && programCounter[21:14] == 8'h01 |=> accessGranted && readData == $past(memReadData))
    else $error("own read refused");
  a_beyond_mem_zero: assert property (accessValid && !accessWrite && tablePointer >= MEM_BYTES
    && tablePointer < ID_FIRST_ADDR |=> readData == 8'h00) else $error("ghost data");
endmodule
bind code_protection_checker code_protection_checker_props #(.MEM_BYTES(MEM_BYTES)) props_i (.clk(clk),
  .reset_n(reset_n), .accessValid(accessValid), .accessWrite(accessWrite), .accessExternal(accessExternal),
  .tablePointer(tablePointer), .programCounter(programCounter), .memReadData(memReadData), .dataValid(dataValid),
  .dataWrite(dataWrite), .dataExternal(dataExternal), .chipErase(chipErase), .blockErase(blockErase),
  .accessDone(accessDone), .accessGranted(accessGranted), .readData(readData), .memWriteEnable(memWriteEnable),
  .dataGranted(dataGranted), .configWriteProtect(configWriteProtect));

// ===== mem_array_model.sv
// program memory array model answering table reads
`timescale 1ns/1ps
module mem_array_model
(
  // table pointer in, byte out in the same cycle
  input wire logic [21:0] addr,
  output logic [7:0] data
);
  // address-derived pattern so a wrong pointer shows as wrong data
  assign data = addr[7:0] ^ addr[15:8] ^ 8'h5a;
endmodule

// ===== tb_top.sv
// self-checking bench for the code protection checker
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top import code_protection_pkg::*;;
  logic clk = 1'b0, reset_n = 1'b0, accessValid = 1'b0, accessWrite = 1'b0, accessExternal = 1'b0;
  logic dataValid = 1'b0, dataWrite = 1'b0, dataExternal = 1'b0, chipErase = 1'b0, blockErase = 1'b0;
  logic [21:0] tablePointer = 22'h000000, programCounter = 22'h000000;
  logic [7:0] writeData = 8'h00, memReadData, readData;
  logic [2:0] eraseRegion = 3'h0;
  logic accessDone, accessGranted, memWriteEnable, dataGranted, configWriteProtect;
  int num_errors = 0, check_count = 0;
  localparam logic [7:0] ERASED [6] = '{BLOCKS_MASK_FULL, BOOT_DATA_MASK, BLOCKS_MASK_FULL,
    WRITE_BOOT_DATA_CFG_MASK, BLOCKS_MASK_FULL, READ_BOOT_MASK};
  logic [7:0] protByte [6];
  logic [21:0] regBase [5] = '{22'h000100, 22'h000900, 22'h004100, 22'h008100, 22'h00c100};
  code_protection_checker code_protection_checker_i (.clk(clk), .reset_n(reset_n), .accessValid(accessValid),
    .accessWrite(accessWrite), .accessExternal(accessExternal), .tablePointer(tablePointer),
    .programCounter(programCounter), .writeData(writeData), .memReadData(memReadData), .dataValid(dataValid),
    .dataWrite(dataWrite), .dataExternal(dataExternal), .chipErase(chipErase), .blockErase(blockErase),
    .eraseRegion(eraseRegion), .accessDone(accessDone), .accessGranted(accessGranted), .readData(readData),
    .memWriteEnable(memWriteEnable), .dataGranted(dataGranted), .configWriteProtect(configWriteProtect));
  mem_array_model mem_array_model_i (.addr(tablePointer), .data(memReadData));
  initial
  begin
    forever #5 clk = ~clk;
  end
  // region index of an address, 4 for boot, -1 beyond memory
  function automatic int rg(input logic [21:0] a);
    if (a < 22'h000800)
      return 4;
    if (a < MEM_64K)
      return int'(a[15:14]);
    return -1;
  endfunction
  // protection bit of a region; boot bits live in the odd byte, bit 6
  function automatic logic pbit(input int k, input int r);
    return (r == 4) ? protByte[k + 1][BOOT_BIT] : protByte[k][r];
  endfunction
  // one table access, expectation worked out before it is issued
  task automatic acc(input logic w, input logic e, input logic [21:0] p, input logic [21:0] c, input logic [7:0] d);
    int r;
    int k;
    logic g;
    logic [7:0] rd;
    r = rg(p);
    k = int'(p) - 'h300008;
    rd = 8'h00;
    if (p >= ID_FIRST_ADDR && p <= ID_LAST_ADDR)
      g = 1'b1;
    else if (p >= CONFIG_BASE_ADDR)
      g = !w || (protByte[3][CFG_BIT] && (e || k != 3));
    else if (r < 0)
      g = !w;
    else
      g = !(e && !pbit(0, r)) && !(w && !pbit(2, r)) && (e || w || pbit(4, r) || rg(c) == r);
    if (g && !w)
      rd = (p >= CONFIG_BASE_ADDR) ? protByte[k] : (r < 0 && p < ID_FIRST_ADDR) ? 8'h00 : p[7:0] ^ p[15:8] ^ 8'h5a;
    @(negedge clk);
    accessValid = 1'b1;
    accessWrite = w;
    accessExternal = e;
    tablePointer = p;
    programCounter = c;
    writeData = d;
    @(negedge clk);
    `CHK(accessDone, 1'b1)
    `CHK(accessGranted, g)
    `CHK(readData, rd)
    `CHK(memWriteEnable, g && w && p < CONFIG_BASE_ADDR)
    if (g && w && k >= 0 && k < 6)
      protByte[k] = protByte[k] & d;
    accessValid = 1'b0;
  endtask
  // every data memory request kind against the model bits
  task automatic datAll();
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk);
      dataValid = 1'b1;
      dataWrite = i[0];
      dataExternal = i[1];
      @(negedge clk);
      `CHK(dataGranted, !(i[0] && !protByte[3][DATA_BIT]) && !(i[1] && !protByte[1][DATA_BIT]))
      dataValid = 1'b0;
    end
  endtask
  task automatic readBack();
    for (int k = 0; k < 6; k++)
      acc(1'b0, 1'b0, CODE_PROTECT_BLOCKS_ADDR + 22'(k), 22'h0, 8'h00);
  endtask
  // programmer erase pulse; block erase restores the region's three bits only
  // the pins pass two synchroniser flops, so the bits change on the third rising edge after the pulse is raised
  task automatic erase(input logic chip, input logic [2:0] rgn);
    @(negedge clk);
    chipErase = chip;
    blockErase = !chip;
    eraseRegion = rgn;
    @(negedge clk);
    chipErase = 1'b0;
    blockErase = 1'b0;
    repeat (2) @(negedge clk);
    for (int k = 0; k < 6; k++)
      if (chip)
        protByte[k] = ERASED[k];
      else if (rgn == 3'h4)
        protByte[k] = protByte[k] | ((k % 2) ? 8'h40 : 8'h00);
      else if (k % 2 == 0)
        protByte[k][rgn] = 1'b1;
  endtask
  task automatic complete_run();
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the sequence needs
  initial
  begin
    #50000;
    num_errors++;
    complete_run();
  end
  initial
  begin
    logic [21:0] p;
    void'($urandom(32'h4ea4));
    protByte = ERASED;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    `CHK(configWriteProtect, 1'b1)
    readBack();
    for (int i = 0; i < 8; i++)
      acc(i[0], 1'b0, ID_FIRST_ADDR + 22'(i), 22'h004000, 8'($urandom));
    datAll();
    acc(1'b1, 1'b0, CODE_PROTECT_BLOCKS_ADDR, 22'h0, 8'h05);
    acc(1'b1, 1'b0, CODE_PROTECT_BOOT_DATA_ADDR, 22'h0, 8'h40);
    for (int i = 0; i < 5; i++)
    begin
      acc(1'b0, 1'b1, regBase[i], 22'h0, 8'h00);
      acc(1'b1, 1'b1, regBase[i], 22'h0, 8'($urandom));
    end
    datAll();
    acc(1'b1, 1'b0, WRITE_PROTECT_BLOCKS_ADDR, 22'h0, 8'($urandom));
    acc(1'b1, 1'b0, TABLE_READ_PROTECT_BLOCKS_ADDR, 22'h0, 8'($urandom));
    acc(1'b1, 1'b0, TABLE_READ_PROTECT_BOOT_ADDR, 22'h0, 8'h00);
    acc(1'b1, 1'b0, TABLE_READ_PROTECT_BLOCKS_ADDR, 22'h0, 8'hff);
    readBack();
    acc(1'b0, 1'b0, regBase[2] + 22'h000010, regBase[2], 8'h00);
    // mixed reads and writes, own-region and foreign, plus unimplemented space
    for (int i = 0; i < 80; i++)
    begin
      p = ($urandom % 6 == 5) ? 22'h012345 : regBase[$urandom % 5] + 22'($urandom % 256);
      acc(1'($urandom), 1'b0, p, regBase[$urandom % 5], 8'($urandom));
    end
    acc(1'b1, 1'b0, WRITE_PROTECT_BOOT_DATA_CFG_ADDR, 22'h0, 8'h00);
    acc(1'b1, 1'b1, WRITE_PROTECT_BOOT_DATA_CFG_ADDR, 22'h0, 8'h1f);
    `CHK(configWriteProtect, 1'b0)
    acc(1'b1, 1'b1, CODE_PROTECT_BLOCKS_ADDR, 22'h0, 8'h00);
    acc(1'b1, 1'b0, regBase[0], 22'h0, 8'h11);
    datAll();
    erase(1'b0, 3'h4);
    erase(1'b0, 3'h1);
    readBack();
    erase(1'b1, 3'h0);
    `CHK(configWriteProtect, 1'b1)
    readBack();
    complete_run();
  end
endmodule
